/* File: hdl/asr_defs.svh */
/*
 * Constants of the converter sequencer: register indices, field positions,
 * reset values and timing counts.
 * Assumes inclusion by bare name from the package and the design files.
 */
// Overview of operation
// RULE1 - software waits 3 us after ladder enable
// RULE2 - result split: upper byte, two low bits
// RULE3 - fixed mode converts selected input 0..7
// RULE4 - scan codes sequence from input 0 or 4
// RULE5 - reset selects fixed input 0
// RULE6 - start by bit or trigger fall; busy set
// RULE7 - start bit during conversion restarts it
// RULE8 - trigger edges ignored while converting
// RULE9 - fixed single: once, end, idle, interrupt
// RULE10 - scan single: one scan, end, idle, interrupt
// RULE11 - fixed repeat: interrupt each or fourth
// RULE12 - scan repeat: interrupt per scan, stay busy
// RULE13 - repeat cleared: finish conversion then stop
// RULE14 - halt stops at once; repeat restarts
// RULE15 - one conversion takes 202 prescaler states
// RULE16 - fixed repeat rotates through pairs 0..3
// RULE17 - other modes store by input low bits
// RULE18 - stored flag set on store, cleared on read
// RULE19 - result read clears end flag
// RULE20 - end interrupt is one-cycle pulse
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// register indices; byte address is four times the index
`define ASR_IDX_LO0 12'h2a0
`define ASR_IDX_HI0 12'h2a1
`define ASR_IDX_LO1 12'h2a2
`define ASR_IDX_HI1 12'h2a3
`define ASR_IDX_LO2 12'h2a4
`define ASR_IDX_HI2 12'h2a5
`define ASR_IDX_LO3 12'h2a6
`define ASR_IDX_HI3 12'h2a7
`define ASR_IDX_MODE0 12'h2a8
`define ASR_IDX_MODE1 12'h2a9
`define ASR_IDX_BASE 12'h2a0

// first mode control register fields
`define ASR_M0_START 0
`define ASR_M0_SCAN 1
`define ASR_M0_REPEAT 2
`define ASR_M0_ITM 3
`define ASR_M0_BUSY 6
`define ASR_M0_EOC 7
// second mode control register fields
`define ASR_M1_CH_LSB 0
`define ASR_M1_TRIG 4
`define ASR_M1_IDLE_RUN 5
`define ASR_M1_LADDER 7

`define ASR_LO_ONES 5'h1f
`define ASR_CH_RESET 3'h0
`define ASR_LAST_ROT 2'h3
`define ASR_CONV_STATES 202
`define ASR_LADDER_SETTLE_US 3
`define ASR_CLK_MHZ 20

`endif

/* File: hdl/asr_pkg.sv */
/*
 * Types shared by the converter sequencer and its result memory.
 * Assumes the constants header is reachable by bare name.
 */
`include "asr_defs.svh"

package asr_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} asr_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} asr_apb_rsp_t;

	typedef enum logic [1:0] {
		ASR_IDLE = 2'b00,
		ASR_CONV = 2'b01,
		ASR_HALTED = 2'b10
	} asr_state_t;

	typedef struct packed {
		logic we;
		logic [1:0] waddr;
		logic [9:0] wdata;
		logic [1:0] raddr;
	} asr_mem_req_t;

	// software ladder settle time in cycles: microseconds times clock MHz
	localparam int ASR_SETTLE_CYC =
		`ASR_LADDER_SETTLE_US * `ASR_CLK_MHZ;

endpackage

/* File: hdl/asr_result_mem.sv */
/*
 * Four-word result store of the converter, one word per result pair.
 * Assumes one write and one read port; read data are registered.
 */
`timescale 1ns/100ps

module asr_result_mem #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire asr_pkg::asr_mem_req_t req_i,
	output logic [WIDTH-1:0] rdata_o
);
	import asr_pkg::*;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] word;
		logic [WIDTH-1:0] q;
	} asr_mem_st_t;

	asr_mem_st_t st_reg;
	asr_mem_st_t st_next;

	always_comb begin
		st_next = st_reg;
		if (req_i.we) begin
			st_next.word[req_i.waddr] = req_i.wdata[WIDTH-1:0];
		end
		// read sees the old word on a same-cycle write
		st_next.q = st_reg.word[req_i.raddr];
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_o = st_reg.q;

endmodule

/* File: hdl/asr_seq.sv */
/*
 * Converter sequencer and result bank: mode registers, channel
 * sequencing, conversion timing, result storage and read-clear flags,
 * reached over an APB slave.
 * Assumes the comparator result arrives on conv_data_i and is valid when
 * a conversion ends, and that halt inputs and the trigger pin are
 * synchronous to clk_i.
 */
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`include "asr_defs.svh"

module asr_seq #(
	parameter int PRESC_DIV = 1,
	parameter int CONV_STATES = `ASR_CONV_STATES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire asr_pkg::asr_apb_req_t apb_i,
	output asr_pkg::asr_apb_rsp_t apb_o,
	input wire logic [9:0] conv_data_i,
	input wire logic ext_trigger_pin_n_i,
	input wire logic light_halt_mode_i,
	input wire logic medium_halt_mode_i,
	input wire logic deep_halt_mode_i,
	output logic [2:0] active_channel_o,
	output logic ref_ladder_enable_o,
	output logic conv_end_irq_o
);
	import asr_pkg::*;

	typedef struct packed {
		asr_state_t state;
		logic scan;
		logic repeat_sel;
		logic itm;
		logic busy;
		logic eoc;
		logic [2:0] chsel;
		logic trig_en;
		logic idle_run;
		logic ladder;
		logic run_repeat;
		logic [2:0] ch;
		logic [1:0] rot;
		logic [3:0] stored;
		logic [15:0] presc;
		logic [7:0] states;
		logic trig_prev;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} asr_st_t;

	asr_st_t st_reg;
	asr_st_t st_next;
	asr_mem_req_t mem_req;
	logic [9:0] mem_q;

	function automatic logic [11:0] reg_index(input logic [11:0] addr);
		reg_index = {2'b00, addr[11:2]};
	endfunction

	function automatic logic is_result(input logic [11:0] idx);
		is_result = (idx >= `ASR_IDX_LO0) && (idx <= `ASR_IDX_HI3);
	endfunction

	function automatic logic [1:0] pair_of(input logic [11:0] idx);
		logic [11:0] off;
		off = idx - `ASR_IDX_BASE;
		pair_of = off[2:1];
	endfunction

	function automatic logic [2:0] first_ch(input logic scan,
		input logic [2:0] sel);
		first_ch = scan ? {sel[2], 2'b00} : sel; // RULE3 RULE4
	endfunction

	asr_result_mem #(
		.WIDTH(10),
		.DEPTH(4)
	) u_mem (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.req_i(mem_req),
		.rdata_o(mem_q)
	);

	logic [11:0] idx;
	logic access;
	logic done_xfer;
	logic wr_done;
	logic rd_done;
	logic start_sw;
	logic trig_fall;
	logic halt_now;
	logic tick;
	logic conv_done;
	logic last_in_scan;
	logic [1:0] store_pair;
	logic mapped;

	always_comb begin
		idx = reg_index(apb_i.paddr);
		access = apb_i.psel && apb_i.penable;
		done_xfer = access && st_reg.pready;
		wr_done = done_xfer && apb_i.pwrite;
		rd_done = done_xfer && !apb_i.pwrite;
		mapped = is_result(idx) || (idx == `ASR_IDX_MODE0) ||
			(idx == `ASR_IDX_MODE1);
		start_sw = wr_done && (idx == `ASR_IDX_MODE0) &&
			apb_i.pwdata[`ASR_M0_START];
		// RULE8: no edge accepted while a conversion runs
		trig_fall = st_reg.trig_en && st_reg.trig_prev &&
			!ext_trigger_pin_n_i && (st_reg.state != ASR_CONV);
		halt_now = deep_halt_mode_i || medium_halt_mode_i ||
			(light_halt_mode_i && !st_reg.idle_run); // RULE14
		tick = (st_reg.presc == 16'(PRESC_DIV - 1));
		conv_done = (st_reg.state == ASR_CONV) && tick &&
			(st_reg.states == 8'(CONV_STATES - 1)); // RULE15
		last_in_scan = !st_reg.scan ||
			(st_reg.ch[1:0] == st_reg.chsel[1:0]);
		// RULE16 RULE17
		store_pair = (st_reg.run_repeat && !st_reg.scan) ?
			st_reg.rot : st_reg.ch[1:0];
		mem_req.we = conv_done;
		mem_req.waddr = store_pair;
		mem_req.wdata = conv_data_i;
		mem_req.raddr = pair_of(idx);
	end

	always_comb begin
		st_next = st_reg;
		st_next.trig_prev = ext_trigger_pin_n_i;
		st_next.irq = 1'b0; // RULE20
		st_next.pready = 1'b0;
		// error flag stands only beside its pready
		st_next.pslverr = 1'b0;

		// bus answer: one wait cycle, then pready for one cycle
		if (access && !st_reg.pready) begin
			st_next.pready = 1'b1;
			st_next.pslverr = !mapped;
			st_next.prdata = '0;
			if (is_result(idx)) begin
				if (idx[0] == (`ASR_IDX_HI0 & 12'h1)) begin
					st_next.prdata[7:0] = mem_q[9:2]; // RULE2
				end else begin
					st_next.prdata[7:0] = {mem_q[1:0], `ASR_LO_ONES,
						st_reg.stored[pair_of(idx)]}; // RULE2
				end
			end else if (idx == `ASR_IDX_MODE0) begin
				st_next.prdata[`ASR_M0_SCAN] = st_reg.scan;
				st_next.prdata[`ASR_M0_REPEAT] = st_reg.repeat_sel;
				st_next.prdata[`ASR_M0_ITM] = st_reg.itm;
				st_next.prdata[`ASR_M0_BUSY] = st_reg.busy;
				st_next.prdata[`ASR_M0_EOC] = st_reg.eoc;
			end else if (idx == `ASR_IDX_MODE1) begin
				st_next.prdata[`ASR_M1_CH_LSB+:3] = st_reg.chsel;
				st_next.prdata[`ASR_M1_TRIG] = st_reg.trig_en;
				st_next.prdata[`ASR_M1_IDLE_RUN] = st_reg.idle_run;
				st_next.prdata[`ASR_M1_LADDER] = st_reg.ladder;
			end
		end

		// read side effects; a same-cycle store wins below
		if (rd_done && is_result(idx)) begin
			st_next.stored[pair_of(idx)] = 1'b0; // RULE18
			st_next.eoc = 1'b0; // RULE19
		end

		if (wr_done && idx == `ASR_IDX_MODE0) begin
			st_next.scan = apb_i.pwdata[`ASR_M0_SCAN];
			st_next.repeat_sel = apb_i.pwdata[`ASR_M0_REPEAT];
			st_next.itm = apb_i.pwdata[`ASR_M0_ITM];
		end
		if (wr_done && idx == `ASR_IDX_MODE1) begin
			st_next.chsel = apb_i.pwdata[`ASR_M1_CH_LSB+:3];
			st_next.trig_en = apb_i.pwdata[`ASR_M1_TRIG];
			st_next.idle_run = apb_i.pwdata[`ASR_M1_IDLE_RUN];
			// RULE1: settle wait before start is software's job
			st_next.ladder = apb_i.pwdata[`ASR_M1_LADDER];
		end

		// prescaler state divider
		if (st_reg.state == ASR_CONV) begin
			st_next.presc = tick ? '0 : st_reg.presc + 16'h0001;
			if (tick) begin
				st_next.states = st_reg.states + 8'h01;
			end
		end

		unique case (st_reg.state)
			ASR_IDLE: begin
			end
			ASR_CONV: begin
				if (conv_done) begin
					st_next.states = '0;
					st_next.stored[store_pair] = 1'b1; // RULE18
					st_next.rot = st_reg.rot + 2'h1; // RULE16
					if (st_reg.run_repeat && !st_reg.repeat_sel) begin
						// RULE13: this conversion ends the run
						st_next.eoc = 1'b1;
						st_next.busy = 1'b0;
						st_next.irq = 1'b1;
						st_next.state = ASR_IDLE;
					end else if (!st_reg.run_repeat) begin
						if (last_in_scan) begin
							st_next.eoc = 1'b1; // RULE9 RULE10
							st_next.busy = 1'b0;
							st_next.irq = 1'b1;
							st_next.state = ASR_IDLE;
						end else begin
							st_next.ch = st_reg.ch + 3'h1; // RULE4
						end
					end else if (st_reg.scan) begin
						if (last_in_scan) begin
							st_next.eoc = 1'b1; // RULE12
							st_next.irq = 1'b1;
							st_next.ch = first_ch(1'b1, st_reg.chsel);
						end else begin
							st_next.ch = st_reg.ch + 3'h1;
						end
					end else begin
						st_next.eoc = 1'b1; // RULE11
						st_next.irq = !st_reg.itm ||
							(st_reg.rot == `ASR_LAST_ROT);
					end
				end
				if (halt_now) begin
					// RULE14: abort now; repeat waits for release
					st_next.presc = '0;
					st_next.states = '0;
					// an aborted conversion raises no request
					st_next.irq = 1'b0;
					st_next.state = st_reg.run_repeat ?
						ASR_HALTED : ASR_IDLE;
					st_next.busy = st_reg.run_repeat;
				end
			end
			ASR_HALTED: begin
				if (!halt_now) begin
					// RULE14: repeat restarts from the beginning
					st_next.state = ASR_CONV;
					st_next.ch = first_ch(st_reg.scan, st_reg.chsel);
					st_next.rot = '0;
				end
			end
			default: begin
				st_next.state = ASR_IDLE;
				st_next.busy = 1'b0;
			end
		endcase

		// stores win over read clears: flag set above follows reads
		if (conv_done) begin
			st_next.stored[store_pair] = 1'b1;
		end

		// RULE6 RULE7: software start also restarts a running one
		if ((start_sw || trig_fall) && !halt_now) begin
			st_next.state = ASR_CONV;
			st_next.busy = 1'b1;
			st_next.run_repeat = start_sw ?
				apb_i.pwdata[`ASR_M0_REPEAT] : st_reg.repeat_sel;
			st_next.ch = start_sw ?
				first_ch(apb_i.pwdata[`ASR_M0_SCAN],
				st_reg.chsel) : first_ch(st_reg.scan, st_reg.chsel);
			st_next.rot = '0;
			st_next.presc = '0;
			st_next.states = '0;
		end
		if (start_sw) begin
			st_next.scan = apb_i.pwdata[`ASR_M0_SCAN];
			st_next.repeat_sel = apb_i.pwdata[`ASR_M0_REPEAT];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= '0;
			st_reg.state <= ASR_IDLE;
			st_reg.scan <= 1'b0; // RULE5
			st_reg.chsel <= `ASR_CH_RESET; // RULE5
			st_reg.trig_prev <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		apb_o.prdata = st_reg.prdata;
		apb_o.pready = st_reg.pready;
		apb_o.pslverr = st_reg.pslverr;
		active_channel_o = st_reg.ch;
		ref_ladder_enable_o = st_reg.ladder;
		conv_end_irq_o = st_reg.irq;
	end

endmodule

/* File: testbench/asr_analog_model.sv */
/* Analog inputs seen by the comparator: each input gives a level made of
   its number and a bench-chosen salt. Assumes a settled channel output. */
`timescale 1ns/100ps
module asr_analog_model (
	input wire logic [2:0] ch_i,
	input wire logic [6:0] salt_i,
	output logic [9:0] level_o
);
	// level names its input so a wrong channel shows in the result
	assign level_o = {ch_i, salt_i};
endmodule

/* File: testbench/asr_seq_props.sv */
/* Port assertions for the converter sequencer.
   Assumes it is bound onto asr_seq with the same conversion count. */
`timescale 1ns/100ps
`include "asr_defs.svh"
module asr_seq_props import asr_pkg::*; #(
	parameter int CONV_STATES = 202
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire asr_pkg::asr_apb_req_t apb_i,
	input wire asr_pkg::asr_apb_rsp_t apb_o,
	input wire logic [9:0] conv_data_i,
	input wire logic ext_trigger_pin_n_i,
	input wire logic light_halt_mode_i,
	input wire logic medium_halt_mode_i,
	input wire logic deep_halt_mode_i,
	input wire logic [2:0] active_channel_o,
	input wire logic ref_ladder_enable_o,
	input wire logic conv_end_irq_o
);
	logic [15:0] gap_reg;
	logic [11:0] idx;
	logic mapped, wr_start;
	assign idx = {2'b00, apb_i.paddr[11:2]};
	assign mapped = idx >= `ASR_IDX_BASE && idx <= `ASR_IDX_MODE1;
	assign wr_start = apb_o.pready && apb_i.pwrite &&
		idx == `ASR_IDX_MODE0 && apb_i.pwdata[0];
	// cycles since the last start or end; saturates, never wraps
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			gap_reg <= 16'h0;
		else if (wr_start || conv_end_irq_o)
			gap_reg <= 16'h0;
		else if (gap_reg != 16'hffff)
			gap_reg <= gap_reg + 16'h1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_irq_pulse: assert property (
		conv_end_irq_o |=> !conv_end_irq_o) else $error("end pulse too long");
	a_conv_time: assert property (
		conv_end_irq_o |-> gap_reg >= 16'(CONV_STATES - 1))
		else $error("conversion ended too early");
	a_reset_state: assert property (
		$past(rst_i) |-> active_channel_o == 3'h0 && !conv_end_irq_o)
		else $error("bad state after reset");
	a_lo_ones: assert property (
		apb_o.pready && !apb_i.pwrite && mapped && idx < `ASR_IDX_MODE0 &&
		!idx[0] |-> apb_o.prdata[5:1] == 5'h1f) else $error("lo ones lost");
	a_halt_quiet: assert property (
		(deep_halt_mode_i || medium_halt_mode_i) [*2] |-> !conv_end_irq_o)
		else $error("end pulse while halted");
	a_ready_late: assert property (
		apb_i.psel && !apb_i.penable |=> !apb_o.pready ##1 apb_o.pready)
		else $error("ready not in second access cycle");
	a_err_unmapped: assert property (
		apb_o.pready |-> apb_o.pslverr == !mapped) else $error("bad slverr");
	a_err_data: assert property (
		apb_o.pslverr |-> apb_o.prdata == 32'h0 && $stable(apb_i.paddr))
		else $error("error read data not zero");
	c_irq: cover property (conv_end_irq_o);
	c_err: cover property (apb_o.pslverr);
	c_halt: cover property (deep_halt_mode_i ##1 !deep_halt_mode_i);
endmodule

/* File: testbench/test_adc_sequencer_result_bank.sv */
/* Self-checking bench of the converter sequencer over APB.
   Assumes the design files and the analog model are compiled first. */
`timescale 1ns/100ps
`include "asr_defs.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	fail_count++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_adc_sequencer_result_bank;
	import asr_pkg::*;
	localparam int CS = 16;
	logic clk_i, rst_i, trig_n, deep_h, med_h, light_h, err, ladder, irq;
	logic [6:0] salt;
	logic [9:0] level;
	logic [2:0] chan, code;
	logic [7:0] q;
	int fail_count, samples_checked;
	asr_apb_req_t req;
	asr_apb_rsp_t rsp;
	asr_seq #(.PRESC_DIV(1), .CONV_STATES(CS)) DUT (.clk_i(clk_i),
		.rst_i(rst_i), .apb_i(req), .apb_o(rsp), .conv_data_i(level),
		.ext_trigger_pin_n_i(trig_n), .light_halt_mode_i(light_h),
		.medium_halt_mode_i(med_h), .deep_halt_mode_i(deep_h),
		.active_channel_o(chan), .ref_ladder_enable_o(ladder),
		.conv_end_irq_o(irq));
	asr_analog_model u_far (.ch_i(chan), .salt_i(salt), .level_o(level));
	task automatic summarize;
		$display("checks %0d errors %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [11:0] i,
		input logic [7:0] d);
		int n;
		@(posedge clk_i);
		req.psel <= 1'b1;
		req.pwrite <= w;
		req.paddr <= {i[9:0], 2'b00};
		req.pwdata <= {24'h0, d};
		@(posedge clk_i);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (rsp.pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			$display("[ERR] %0t no bus ready", $time);
			summarize();
		end
		q = rsp.prdata[7:0];
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wirq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 3000) begin
			fail_count++;
			$display("[ERR] %0t no end request", $time);
			summarize();
		end
	endtask
	// reads both bytes of a pair, then the low byte again for a clear flag
	task automatic chk_pair(input logic [1:0] p, input logic [2:0] ch);
		logic [9:0] l;
		l = {ch, salt};
		bus(1'b0, `ASR_IDX_BASE + {9'h0, p, 1'b0}, 8'h0);
		`CHK(q, {l[1:0], 5'h1f, 1'b1})
		bus(1'b0, `ASR_IDX_BASE + {9'h0, p, 1'b1}, 8'h0);
		`CHK(q, l[9:2])
		bus(1'b0, `ASR_IDX_BASE + {9'h0, p, 1'b0}, 8'h0);
		`CHK(q[0], 1'b0)
	endtask
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		void'($urandom(34384));
		{rst_i, trig_n, deep_h, med_h, light_h, salt, req} = '0;
		rst_i = 1'b1;
		trig_n = 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, `ASR_IDX_MODE1, 8'h0);
		`CHK(q, 8'h00)
		bus(1'b0, 12'h2b0, 8'h0);
		`CHK({err, q}, 9'h100)
		bus(1'b1, `ASR_IDX_MODE1, 8'h80);
		@(posedge clk_i);
		`CHK(ladder, 1'b1)
		repeat (ASR_SETTLE_CYC) @(posedge clk_i);
		for (int m = 0; m < 16; m++) begin
			code = m[2:0];
			salt <= 7'($urandom);
			bus(1'b1, `ASR_IDX_MODE1, {5'h10, code});
			bus(1'b1, `ASR_IDX_MODE0, m[3] ? 8'h03 : 8'h01);
			wirq();
			bus(1'b0, `ASR_IDX_MODE0, 8'h0);
			`CHK(q & 8'hc0, 8'h80)
			for (int k = 0; k <= (m[3] ? int'(code[1:0]) : 0); k++)
				chk_pair(2'(k) + (m[3] ? 2'h0 : code[1:0]),
					(m[3] ? {code[2], 2'h0} : code) + 3'(k));
			bus(1'b0, `ASR_IDX_MODE0, 8'h0);
			`CHK(q[7], 1'b0)
		end
		bus(1'b1, `ASR_IDX_MODE1, 8'h85);
		bus(1'b1, `ASR_IDX_MODE0, 8'h0d);
		wirq();
		bus(1'b1, `ASR_IDX_MODE0, 8'h00);
		wirq();
		bus(1'b0, `ASR_IDX_MODE0, 8'h0);
		`CHK(q & 8'hc0, 8'h80)
		for (int p = 0; p < 4; p++)
			chk_pair(2'(p), 3'h5);
		bus(1'b1, `ASR_IDX_MODE1, 8'h92);
		@(posedge clk_i);
		trig_n <= 1'b0;
		bus(1'b0, `ASR_IDX_MODE0, 8'h0);
		`CHK(q[6], 1'b1)
		trig_n <= 1'b1;
		repeat (2) @(posedge clk_i);
		trig_n <= 1'b0;
		wirq();
		repeat (3) @(posedge clk_i);
		bus(1'b0, `ASR_IDX_MODE0, 8'h0);
		`CHK(q & 8'hc0, 8'h80)
		chk_pair(2'h2, 3'h2);
		bus(1'b1, `ASR_IDX_MODE1, 8'h81);
		bus(1'b1, `ASR_IDX_MODE0, 8'h01);
		repeat (4) @(posedge clk_i);
		deep_h <= 1'b1;
		repeat (30) @(posedge clk_i);
		deep_h <= 1'b0;
		bus(1'b0, `ASR_IDX_MODE0, 8'h0);
		`CHK(q[6], 1'b0)
		bus(1'b1, `ASR_IDX_MODE0, 8'h05);
		med_h <= 1'b1;
		repeat (30) @(posedge clk_i);
		med_h <= 1'b0;
		wirq();
		bus(1'b1, `ASR_IDX_MODE0, 8'h00);
		wirq();
		bus(1'b0, `ASR_IDX_MODE0, 8'h0);
		`CHK(q[6], 1'b0)
		// scan repeat over inputs 4..6, then stopped mid-scan
		bus(1'b1, `ASR_IDX_MODE1, 8'h86);
		bus(1'b1, `ASR_IDX_MODE0, 8'h07);
		wirq();
		bus(1'b0, `ASR_IDX_MODE0, 8'h0);
		`CHK(q & 8'hc0, 8'hc0)
		bus(1'b1, `ASR_IDX_MODE0, 8'h02);
		wirq();
		bus(1'b0, `ASR_IDX_MODE0, 8'h0);
		`CHK(q & 8'hc0, 8'h80)
		for (int p = 0; p < 3; p++)
			chk_pair(2'(p), 3'h4 + 3'(p));
		// light halt with idle-run set must not stop the converter
		bus(1'b1, `ASR_IDX_MODE1, 8'ha1);
		light_h <= 1'b1;
		bus(1'b1, `ASR_IDX_MODE0, 8'h01);
		wirq();
		light_h <= 1'b0;
		summarize();
	end
endmodule
bind asr_seq asr_seq_props #(.CONV_STATES(CONV_STATES)) u_props (
	.clk_i(clk_i), .rst_i(rst_i), .apb_i(apb_i), .apb_o(apb_o),
	.conv_data_i(conv_data_i), .ext_trigger_pin_n_i(ext_trigger_pin_n_i),
	.light_halt_mode_i(light_halt_mode_i),
	.medium_halt_mode_i(medium_halt_mode_i),
	.deep_halt_mode_i(deep_halt_mode_i),
	.active_channel_o(active_channel_o),
	.ref_ladder_enable_o(ref_ladder_enable_o),
	.conv_end_irq_o(conv_end_irq_o));
